// ---- core/spc_pkg.sv ----
// types for the shared pin control block
package spc_pkg;
  typedef struct packed {
    logic [35:0] out_val;
    logic [35:0] out_en;
    logic [35:0] pull_up;
    logic [35:0] pull_dn;
  } spc_pad_ctl_type;
  typedef struct packed {
    logic       pin_enable;
    logic       rising;
  } spc_ext_int_cfg_type;
  typedef enum logic [1:0] {
    SPC_ST_RESET = 2'b00,
    SPC_ST_RUN   = 2'b01
  } spc_state_type;
endpackage

// ---- core/spc_regs.svh ----
// constants for the shared pin control block
`ifndef SPC_REGS_SVH
`define SPC_REGS_SVH
`define SPC_NUM_PINS      36
`define SPC_KWU_LO        4
`define SPC_KWU_HI        7
`define SPC_RST_DDR       36'h0_0000_0000
`define SPC_RST_PULL_EN   36'h0_0000_0000
`define SPC_RST_DATA      36'h0_0000_0000
`endif

// ---- core/spc_shared_pin_control.sv ----
// shared pin control: pad enables, pulls and port read data for 36 pins
// Function
// - After reset all 36 pins are inputs, undriven, with every pull off.
// - Port data reads follow the direction bit even when a peripheral owns a pin.
// - An owning peripheral drives the pin's output buffer enable.
// - Pull enable bit switches the pull device whenever the pin is an input.
// - Upper port A keypad pins sensing rising or high use pulldowns instead.
// - Enabled external interrupt set for rising edges uses a pulldown instead of pullup.
// - External interrupt input works only once its pin enable is set; input only.
// - Enabled external interrupt forces pullup for falling, pulldown for rising edges.
`timescale 1ns/100ps
`include "spc_regs.svh"
module spc_shared_pin_control
  import spc_pkg::*;
#(
  parameter int NUM_PINS = `SPC_NUM_PINS
) (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                arst_n,
  // port registers written by software
  input  wire logic [NUM_PINS-1:0] port_data,
  input  wire logic [NUM_PINS-1:0] port_dir,
  input  wire logic [NUM_PINS-1:0] port_pull_en,
  // peripheral side
  input  wire logic [NUM_PINS-1:0] periph_own,
  input  wire logic [NUM_PINS-1:0] periph_out,
  input  wire logic [NUM_PINS-1:0] periph_oe,
  input  wire logic [3:0]          keypad_wake_rising,
  input  spc_ext_int_cfg_type      ext_int_cfg,
  input  wire logic                ext_int_pull_en,
  // package pins
  input  wire logic [NUM_PINS-1:0] pin_in,
  input  wire logic                ext_int_pin,
  // outputs
  output spc_pad_ctl_type          pad_ctl,
  output logic [NUM_PINS-1:0]      port_read,
  output logic                     ext_int_in,
  output logic                     ext_int_pull_up,
  output logic                     ext_int_pull_dn
);

  spc_state_type   state_reg, state_next;
  spc_pad_ctl_type pad_reg, pad_next;
  logic [NUM_PINS-1:0] read_reg, read_next;
  logic            xi_in_reg, xi_in_next;
  logic            xi_up_reg, xi_up_next;
  logic            xi_dn_reg, xi_dn_next;

  // per-pin results of the ownership and pull decode
  logic [NUM_PINS-1:0] pin_oe;
  logic [NUM_PINS-1:0] pin_lvl;
  logic [NUM_PINS-1:0] pin_pull;
  logic [NUM_PINS-1:0] pin_pdn;
  logic [NUM_PINS-1:0] pin_rd;

  // external interrupt pad decode
  logic                xi_gate;
  logic                xi_up;
  logic                xi_dn;

  // true when the pin is one of the upper port A keypad wake inputs
  function automatic logic is_kwu_pin(input int idx);
    is_kwu_pin = (idx >= `SPC_KWU_LO) && (idx <= `SPC_KWU_HI);
  endfunction

  // two-way choice shared by the enable, level, read and pull decode
  function automatic logic pick(input logic sel, input logic when_set, input logic when_clr);
    pick = sel ? when_set : when_clr;
  endfunction

  generate
    for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
      // owner of the output buffer enable
      assign pin_oe[g]   = pick(periph_own[g], periph_oe[g], port_dir[g]);

      // level driven while the buffer is on
      assign pin_lvl[g]  = pick(periph_own[g], periph_out[g], port_data[g]);

      // pull bit acts whenever the pin is an input, owned or not
      assign pin_pull[g] = port_pull_en[g] & ~pin_oe[g];

      // port data reads follow the direction bit, never the owner
      assign pin_rd[g]   = pick(port_dir[g], port_data[g], pin_in[g]);

      if (is_kwu_pin(g)) begin : g_kwu
        // keypad unit sensing rising or high turns the pull into a pulldown
        assign pin_pdn[g] = periph_own[g] & keypad_wake_rising[g-`SPC_KWU_LO];
      end else begin : g_plain
        // every other pin only ever pulls up
        assign pin_pdn[g] = 1'b0;
      end
    end
  endgenerate

  // the interrupt pin has no drive at all; only the gated input and pulls exist
  assign xi_gate = ext_int_cfg.pin_enable & ext_int_pin;

  // enabled: edge select forces one pull; disabled: the pull bit acts as pullup
  assign xi_up   = pick(ext_int_cfg.pin_enable, ~ext_int_cfg.rising, ext_int_pull_en);
  assign xi_dn   = ext_int_cfg.pin_enable & ext_int_cfg.rising;

  always_comb begin
    state_next = state_reg;
    pad_next   = '0;
    read_next  = '0;
    xi_in_next = 1'b0;
    xi_up_next = 1'b0;
    xi_dn_next = 1'b0;
    case (state_reg)
      SPC_ST_RESET: begin
        // first edge after release keeps every output off
        state_next = SPC_ST_RUN;
      end
      SPC_ST_RUN: begin
        state_next       = SPC_ST_RUN;
        pad_next.out_en  = pin_oe;
        pad_next.out_val = pin_lvl;
        pad_next.pull_up = pin_pull & ~pin_pdn;
        pad_next.pull_dn = pin_pull & pin_pdn;
        read_next        = pin_rd;
        xi_in_next       = xi_gate;
        xi_up_next       = xi_up;
        xi_dn_next       = xi_dn;
      end
      default: begin
        // unused code falls back to the all-off state
        state_next = SPC_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg       <= SPC_ST_RESET;
      pad_reg.out_val <= `SPC_RST_DATA;
      pad_reg.out_en  <= `SPC_RST_DDR;
      pad_reg.pull_up <= `SPC_RST_PULL_EN;
      pad_reg.pull_dn <= `SPC_RST_PULL_EN;
      read_reg        <= '0;
      xi_in_reg       <= 1'b0;
      xi_up_reg       <= 1'b0;
      xi_dn_reg       <= 1'b0;
    end else begin
      state_reg <= state_next;
      pad_reg   <= pad_next;
      read_reg  <= read_next;
      xi_in_reg <= xi_in_next;
      xi_up_reg <= xi_up_next;
      xi_dn_reg <= xi_dn_next;
    end
  end

  assign pad_ctl         = pad_reg;
  assign port_read       = read_reg;
  assign ext_int_in      = xi_in_reg;
  assign ext_int_pull_up = xi_up_reg;
  assign ext_int_pull_dn = xi_dn_reg;

endmodule // spc_shared_pin_control

// ---- sim/spc_periph_model.sv ----
// peripheral side: ownership, enables and a toggling output level
`timescale 1ns/100ps
module spc_periph_model (
  input  wire logic        clk_sys,
  input  wire logic [1:0]  mode,
  output logic      [35:0] periph_own, periph_oe, periph_out,
  output logic      [3:0]  keypad_wake_rising);
  always @(posedge clk_sys) begin
    periph_own <= mode[0] ? 36'hF_0000_00FF : 36'h0;
    periph_oe <= mode[1] ? 36'hA_0000_000F : 36'h0;
    periph_out <= (mode == 2'h0) ? 36'h5_5555_5555 : ~periph_out;
    keypad_wake_rising <= mode[1] ? 4'hA : 4'h5;
  end
endmodule // spc_periph_model

// ---- sim/spc_pin_properties.sv ----
// port assertions for the shared pin control block
`timescale 1ns/100ps
module spc_pin_props import spc_pkg::*; #(parameter int NUM_PINS = 36) (
  input wire logic clk_sys, arst_n, ext_int_pin, ext_int_in, ext_int_pull_up, ext_int_pull_dn,
  input wire logic ext_int_pull_en,
  input wire logic [NUM_PINS-1:0] port_data, port_dir, port_pull_en, periph_own, periph_out,
  input wire logic [NUM_PINS-1:0] periph_oe, pin_in, port_read,
  input wire logic [3:0] keypad_wake_rising,
  input spc_ext_int_cfg_type ext_int_cfg,
  input spc_pad_ctl_type pad_ctl);
  logic run1_reg, run2_reg;
  // second stage set means the outputs already follow the inputs
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      run1_reg <= 1'b0;
      run2_reg <= 1'b0;
    end else begin
      run1_reg <= 1'b1;
      run2_reg <= run1_reg;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  rst_off_a: assert property (!run2_reg |->
    {pad_ctl, port_read, ext_int_in, ext_int_pull_up, ext_int_pull_dn} == 0) else $error("not off");
  read_sel_a: assert property (run2_reg |-> port_read == ($past(port_dir) & $past(port_data) |
    ~$past(port_dir) & $past(pin_in))) else $error("read");
  owned_pin_a: assert property (run2_reg |-> ((pad_ctl.out_en ^ $past(periph_oe) |
    pad_ctl.out_val ^ $past(periph_out)) & $past(periph_own)) == 0) else $error("owned");
  free_pin_a: assert property (run2_reg |-> ((pad_ctl.out_en ^ $past(port_dir) |
    pad_ctl.out_val ^ $past(port_data)) & ~$past(periph_own)) == 0) else $error("free");
  pull_on_a: assert property (run2_reg |-> (pad_ctl.pull_up | pad_ctl.pull_dn) ==
    ($past(port_pull_en) & ~pad_ctl.out_en)) else $error("pull");
  keypad_dn_a: assert property (run2_reg |-> pad_ctl.pull_dn[7:4] == ($past(port_pull_en[7:4]) &
    ~pad_ctl.out_en[7:4] & $past(periph_own[7:4]) & $past(keypad_wake_rising))) else $error("kdn");
  ext_gate_a: assert property (run2_reg |-> ext_int_in ==
    ($past(ext_int_cfg.pin_enable) & $past(ext_int_pin))) else $error("gate");
  ext_pull_a: assert property (run2_reg && $past(ext_int_cfg.pin_enable) |->
    ext_int_pull_dn == $past(ext_int_cfg.rising) && ext_int_pull_up != ext_int_pull_dn)
    else $error("epull");
  ext_idle_a: assert property (run2_reg && !$past(ext_int_cfg.pin_enable) |->
    ext_int_pull_up == $past(ext_int_pull_en) && !ext_int_pull_dn && !ext_int_in)
    else $error("eidle");
endmodule // spc_pin_props
bind spc_shared_pin_control spc_pin_props #(.NUM_PINS(NUM_PINS)) chk_u (.*);

// ---- sim/spc_shared_pin_control_tb.sv ----
// self-checking bench for the shared pin control block
`timescale 1ns/100ps
module spc_shared_pin_control_tb import spc_pkg::*; ;
  logic clk_sys = 0, arst_n = 0, rel = 0, ext_int_pull_en = 0, ext_int_pin = 0;
  logic ext_int_in, ext_int_pull_up, ext_int_pull_dn;
  logic [35:0] port_data = 0, port_dir = 0, port_pull_en = 0, pin_in = 0, k, v;
  logic [35:0] periph_own, periph_out, periph_oe, port_read;
  logic [3:0] keypad_wake_rising;
  logic [1:0] mode = 0;
  spc_ext_int_cfg_type ext_int_cfg = 0;
  spc_pad_ctl_type pad_ctl, e;
  logic [182:0] exp_v = 0;
  wire [182:0] act = {pad_ctl, port_read, ext_int_in, ext_int_pull_up, ext_int_pull_dn};
  int err_count = 0, samples_checked = 0, cyc = 0;
  always #10 clk_sys = ~clk_sys;
  spc_periph_model pm_u (.*);
  spc_shared_pin_control dut_u (.*);
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys) if (++cyc > 400) begin err_count++; summarize(); end
  // expectation from inputs held over the coming edge; outputs stay off one edge after release
  always @(negedge clk_sys) begin
    if (arst_n) samples_checked++;
    if (arst_n && act !== exp_v) begin
      err_count++;
      $display("mismatch %0t %h %h", $time, act, exp_v);
    end
    e.out_en = periph_own & periph_oe | ~periph_own & port_dir;
    e.out_val = periph_own & periph_out | ~periph_own & port_data;
    k = {28'h0, periph_own[7:4] & keypad_wake_rising, 4'h0};
    e.pull_up = port_pull_en & ~e.out_en & ~k;
    e.pull_dn = port_pull_en & ~e.out_en & k;
    exp_v = (arst_n && rel) ? {e, port_dir & port_data | ~port_dir & pin_in,
      ext_int_cfg.pin_enable & ext_int_pin, ext_int_cfg.pin_enable ? !ext_int_cfg.rising :
      ext_int_pull_en, ext_int_cfg.pin_enable & ext_int_cfg.rising} : 183'h0;
    rel = arst_n;
  end
  initial begin
    v = 36'h9_A5C3_6F1E;
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (int i = 0; i < 60; i++) begin
      @(posedge clk_sys);
      v = {v[30:0], v[35:31]} ^ 36'(i);
      port_data <= v;
      port_dir <= {v[5:0], v[35:6]};
      port_pull_en <= ~v;
      pin_in <= v ^ 36'h3_0F0F_00FF;
      mode <= v[1:0];
      ext_int_cfg <= v[3:2];
      ext_int_pull_en <= v[4];
      ext_int_pin <= v[5];
      arst_n <= (i != 30);
    end
    repeat (3) @(posedge clk_sys);
    summarize();
  end
endmodule // spc_shared_pin_control_tb
